// [hdl/irmf_flags.sv]
`timescale 1ns/1ps
// Behaviour
// R1: pin six and key return share one flag
// R2: source request or written one sets flag
// R3: acknowledge or software clears the flag
// R4: reset clears every request flag register
// R5: bit, byte and paired word access
// R6: flag register writes stall two extra clocks
// R7: flag reads one while request pends
// R8: software keeps absent request bits cleared
// R9: mask zero allows servicing pending request
// R10: masked requests stay set, not forwarded
// R11: reset sets every mask register to ones
// R12: software clears flags with single-bit clear
// R13: software clears noisy flags after standby
// R14: software keeps absent mask bits set
// R15: two priority bits encode four levels
// R16: simultaneous requests resolved by fixed order
module irmf_flags (
  input  wire logic        core_clk_i,          // system clock
  input  wire logic        reset_n_i,           // async reset, active low
  input  wire logic        mem_sel_i,           // memory access strobe
  input  wire logic        mem_we_i,            // 1 write, 0 read
  input  wire logic [1:0]  mem_size_i,          // bit, byte or word
  input  wire logic [19:0] mem_addr_i,          // byte address
  input  wire logic [2:0]  mem_bit_i,           // bit number for bit ops
  input  wire logic [15:0] mem_wdata_i,         // write data
  output logic             mem_busy_o,          // write stall in progress
  output logic             mem_rvalid_o,        // read data valid pulse
  output logic [15:0]      mem_rdata_o,         // read data
  input  wire logic [63:0] src_req_i,           // source request pulses
  input  wire logic        ext_pin_irq_six_i,   // pin six request pulse
  input  wire logic        key_return_irq_i,    // key return request pulse
  input  wire logic [63:0] priority_bit_low_i,  // priority low bits
  input  wire logic [63:0] priority_bit_high_i, // priority high bits
  input  wire logic        ack_i,               // core acknowledge pulse
  input  wire logic [5:0]  ack_idx_i,           // acknowledged position
  output logic             irq_req_o,           // request to the core
  output logic [5:0]       irq_idx_o,           // requesting position
  output logic [1:0]       irq_level_o          // its priority level
);

  // flag store and bus state
  logic [63:0] req_q;          // request flags, byte k at [8k+7:8k]
  logic [63:0] mask_q;         // mask flags, same layout
  logic [63:0] next_req;       // next request flags
  logic [63:0] next_mask;      // next mask flags
  logic [1:0]  stall_cnt;      // extra clocks still to add
  logic [1:0]  next_stall_cnt;
  logic        next_busy;
  logic        next_rvalid;
  logic [15:0] next_rdata;
  logic        next_irq;
  logic [5:0]  next_idx;
  logic [1:0]  next_level;

  // decode results
  logic        acc_hit;        // address names one of our bytes
  logic        acc_mask;       // 1 mask register, 0 request register
  logic [2:0]  acc_byte;       // byte index 0..7
  logic [2:0]  word_base;      // even byte of a word access
  logic        take;           // access accepted this cycle
  logic        wr_take;        // accepted write
  logic        rd_take;        // accepted read
  logic [63:0] hw_set;         // hardware set requests this cycle
  logic [63:0] ack_clr;        // acknowledge clear this cycle
  logic [63:0] pend;           // pending and unmasked
  logic        pick_found;
  logic [5:0]  pick_idx;
  logic [1:0]  pick_level;

  // a stalled write holds off the next access, so no request is lost
  assign take    = mem_sel_i && !mem_busy_o;
  assign wr_take = take && mem_we_i;
  assign rd_take = take && !mem_we_i;
  assign word_base = {acc_byte[2:1], 1'b0};

  // address decode onto the two register files
  always_comb begin
    acc_hit  = 1'b1;
    acc_mask = 1'b0;
    acc_byte = 3'h0;
    unique case (mem_addr_i)
      irmf_pkg::ADDR_REQ_G0_LO:  acc_byte = 3'h0;
      irmf_pkg::ADDR_REQ_G0_HI:  acc_byte = 3'h1;
      irmf_pkg::ADDR_REQ_G1_LO:  acc_byte = 3'h2;
      irmf_pkg::ADDR_REQ_G1_HI:  acc_byte = 3'h3;
      irmf_pkg::ADDR_REQ_G2_LO:  acc_byte = 3'h4;
      irmf_pkg::ADDR_REQ_G2_HI:  acc_byte = 3'h5;
      irmf_pkg::ADDR_REQ_G3_LO:  acc_byte = 3'h6;
      irmf_pkg::ADDR_REQ_G3_HI:  acc_byte = 3'h7;
      irmf_pkg::ADDR_MASK_G0_LO: begin acc_mask = 1'b1; acc_byte = 3'h0; end
      irmf_pkg::ADDR_MASK_G0_HI: begin acc_mask = 1'b1; acc_byte = 3'h1; end
      irmf_pkg::ADDR_MASK_G1_LO: begin acc_mask = 1'b1; acc_byte = 3'h2; end
      irmf_pkg::ADDR_MASK_G1_HI: begin acc_mask = 1'b1; acc_byte = 3'h3; end
      irmf_pkg::ADDR_MASK_G2_LO: begin acc_mask = 1'b1; acc_byte = 3'h4; end
      irmf_pkg::ADDR_MASK_G2_HI: begin acc_mask = 1'b1; acc_byte = 3'h5; end
      irmf_pkg::ADDR_MASK_G3_LO: begin acc_mask = 1'b1; acc_byte = 3'h6; end
      irmf_pkg::ADDR_MASK_G3_HI: begin acc_mask = 1'b1; acc_byte = 3'h7; end
      // any other address belongs to someone else
      default:                   acc_hit = 1'b0;
    endcase
  end

  // hardware sets: the shared flag takes either of its two sources
  always_comb begin
    hw_set = src_req_i & irmf_pkg::IMPL_BITS;                  // see R2
    if (ext_pin_irq_six_i || key_return_irq_i) begin
      hw_set[irmf_pkg::SHARED_BIT] = 1'b1;                     // see R1
    end
    ack_clr = '0;
    if (ack_i) begin
      ack_clr[ack_idx_i] = 1'b1;                               // see R3
    end
  end

  // next flag values, one byte register per pass
  always_comb begin
    logic [7:0] wm;            // bits written this cycle
    logic [7:0] wv;            // values written
    logic [7:0] cur_r;
    logic [7:0] cur_m;
    wm = 8'h00;
    wv = 8'h00;
    cur_r = 8'h00;
    cur_m = 8'h00;
    next_req  = '0;
    next_mask = '0;
    for (int k = 0; k < irmf_pkg::NUM_BYTES; k++) begin
      wm = 8'h00;
      wv = 8'h00;
      if (wr_take && acc_hit) begin
        unique case (irmf_pkg::irmf_size_t'(mem_size_i))
          // single bit: only the named bit moves (see R5)
          irmf_pkg::SZ_BIT: begin
            if (acc_byte == 3'(k)) begin
              wm = 8'h01 << mem_bit_i;
              wv = {8{mem_wdata_i[0]}};
            end
          end
          irmf_pkg::SZ_BYTE: begin
            if (acc_byte == 3'(k)) begin
              wm = 8'hFF;
              wv = mem_wdata_i[7:0];
            end
          end
          // word: low byte at the even address (see R5)
          irmf_pkg::SZ_WORD: begin
            if (word_base == {2'(k >> 1), 1'b0}) begin
              wm = 8'hFF;
              wv = (k % 2 == 1) ? mem_wdata_i[15:8] : mem_wdata_i[7:0];
            end
          end
          // reserved size code writes nothing
          default: begin
            wm = 8'h00;
          end
        endcase
      end
      cur_r = req_q[k*8 +: 8];
      cur_m = mask_q[k*8 +: 8];
      // set beats any clear in the same cycle, written or acknowledged
      next_req[k*8 +: 8] = ((((cur_r & ~(acc_mask ? 8'h00 : wm))  // see R2
                         | (wv & (acc_mask ? 8'h00 : wm)))
                         & ~ack_clr[k*8 +: 8])                    // see R3
                         | hw_set[k*8 +: 8])
                         & irmf_pkg::IMPL_BITS[k*8 +: 8];         // see R7
      // absent mask bits always read one
      next_mask[k*8 +: 8] = (cur_m & ~(acc_mask ? wm : 8'h00))
                          | (wv & (acc_mask ? wm : 8'h00))
                          | ~irmf_pkg::IMPL_BITS[k*8 +: 8];
    end
  end

  // flag registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_q  <= {irmf_pkg::NUM_BYTES{irmf_pkg::REQ_RESET}};   // see R4
      mask_q <= {irmf_pkg::NUM_BYTES{irmf_pkg::MASK_RESET}};  // see R11
    end else begin
      req_q  <= next_req;
      mask_q <= next_mask;
    end
  end

  // bus answer: write stall count and read data
  always_comb begin
    logic [5:0] lo_base;
    logic [5:0] wd_base;
    logic [63:0] src_vec;
    lo_base = {acc_byte, 3'h0};
    wd_base = {word_base, 3'h0};
    src_vec = acc_mask ? mask_q : req_q;
    next_stall_cnt = stall_cnt;
    if (wr_take && acc_hit) begin
      next_stall_cnt = irmf_pkg::WR_EXTRA_CLKS;                // see R6
    end else if (stall_cnt != 2'h0) begin
      next_stall_cnt = stall_cnt - 2'h1;
    end
    next_busy   = (next_stall_cnt != 2'h0);
    next_rvalid = rd_take;
    next_rdata  = mem_rdata_o;
    if (rd_take) begin
      next_rdata = 16'h0000;                 // unmapped reads give zero
      if (acc_hit) begin
        unique case (irmf_pkg::irmf_size_t'(mem_size_i))
          irmf_pkg::SZ_BIT:
            next_rdata = {15'h0000, src_vec[lo_base + 6'(mem_bit_i)]};
          irmf_pkg::SZ_BYTE:
            next_rdata = {8'h00, src_vec[lo_base +: 8]};       // see R7
          irmf_pkg::SZ_WORD:
            next_rdata = src_vec[wd_base +: 16];               // see R5
          default:
            next_rdata = 16'h0000;
        endcase
      end
    end
  end

  // bus answer registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stall_cnt    <= 2'h0;
      mem_busy_o   <= 1'b0;
      mem_rvalid_o <= 1'b0;
      mem_rdata_o  <= 16'h0000;
    end else begin
      stall_cnt    <= next_stall_cnt;
      mem_busy_o   <= next_busy;
      mem_rvalid_o <= next_rvalid;
      mem_rdata_o  <= next_rdata;
    end
  end

  // a masked request stays visible in its flag but never reaches the core
  assign pend = req_q & ~mask_q;                               // see R10

  irmf_prio_pick #(
    .N (irmf_pkg::FLAG_BITS)
  ) irmf_prio_pick_i (
    .pend_i    (pend),
    .prio_lo_i (priority_bit_low_i),
    .prio_hi_i (priority_bit_high_i),
    .found_o   (pick_found),
    .idx_o     (pick_idx),
    .level_o   (pick_level)
  );

  // forwarded request, one clock behind the flags
  always_comb begin
    next_irq   = pick_found;                                   // see R9
    next_idx   = pick_idx;
    next_level = pick_level;
  end

  // request outputs
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_req_o   <= 1'b0;
      irq_idx_o   <= 6'h00;
      irq_level_o <= 2'h0;
    end else begin
      irq_req_o   <= next_irq;
      irq_idx_o   <= next_idx;
      irq_level_o <= next_level;
    end
  end

  // helper copies of the inputs the forwarded request was computed from
  logic [63:0] req_d;
  logic [63:0] mask_d;
  logic [63:0] plo_d;
  logic [63:0] phi_d;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_d  <= 64'h0;
      mask_d <= 64'h0;
      plo_d  <= 64'h0;
      phi_d  <= 64'h0;
    end else begin
      req_d  <= req_q;
      mask_d <= mask_q;
      plo_d  <= priority_bit_low_i;
      phi_d  <= priority_bit_high_i;
    end
  end

  property p_shared_set;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (ext_pin_irq_six_i || key_return_irq_i) |=>
      req_q[irmf_pkg::SHARED_BIT];
  endproperty
  a_shared_set: assert property (p_shared_set) // see R1
    else $error("shared flag not set");

  property p_src_set;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    1'b1 |=> ((req_q & $past(hw_set)) == $past(hw_set));
  endproperty
  a_src_set: assert property (p_src_set) // see R2
    else $error("source request lost");

  property p_ack_clear;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (ack_i && !hw_set[ack_idx_i] && !wr_take) |=>
      !req_q[$past(ack_idx_i)];
  endproperty
  a_ack_clear: assert property (p_ack_clear) // see R3
    else $error("acknowledged flag not cleared");

  property p_word_read;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (rd_take && mem_addr_i == irmf_pkg::ADDR_REQ_G0_LO
     && mem_size_i == irmf_pkg::SZ_WORD) |=>
      mem_rvalid_o && mem_rdata_o == $past(req_q[15:0]);
  endproperty
  a_word_read: assert property (p_word_read) // see R5
    else $error("word read wrong");

  property p_stall;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (wr_take && acc_hit) |=> mem_busy_o [*2] ##1 !mem_busy_o;
  endproperty
  a_stall: assert property (p_stall) // see R6
    else $error("write stall not two clocks");

  property p_absent_bits;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    ((req_q & ~irmf_pkg::IMPL_BITS) == 64'h0)
      && ((mask_q | irmf_pkg::IMPL_BITS) == 64'hFFFF_FFFF_FFFF_FFFF);
  endproperty
  a_absent_bits: assert property (p_absent_bits) // see R7
    else $error("absent flag bits wrong");

  property p_fwd_unmasked;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    irq_req_o |-> (req_d[irq_idx_o] && !mask_d[irq_idx_o]);
  endproperty
  a_fwd_unmasked: assert property (p_fwd_unmasked) // see R10
    else $error("masked or idle request forwarded");

  property p_fwd_pending;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (pend != 64'h0) |=> irq_req_o;
  endproperty
  a_fwd_pending: assert property (p_fwd_pending) // see R9
    else $error("unmasked request not forwarded");

  property p_level;
    @(posedge core_clk_i) disable iff (!reset_n_i)
    irq_req_o |-> irq_level_o == {phi_d[irq_idx_o], plo_d[irq_idx_o]};
  endproperty
  a_level: assert property (p_level) // see R15
    else $error("level does not match priority bits");

  c_ack: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    irq_req_o ##1 ack_i);
  c_word_wr: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    wr_take && acc_hit && mem_size_i == irmf_pkg::SZ_WORD);
  c_set_vs_clr: cover property (@(posedge core_clk_i)
    disable iff (!reset_n_i) ack_i && hw_set[ack_idx_i]);

endmodule

// [common/irmf_pkg.sv]
package irmf_pkg;

  // flag store geometry: eight byte registers of each kind
  localparam int NUM_BYTES = 8;
  localparam int FLAG_BITS = 64;
  localparam int IDX_W     = 6;

  // byte addresses of the request flag registers
  localparam logic [19:0] ADDR_REQ_G0_LO  = 20'hFFFE0;
  localparam logic [19:0] ADDR_REQ_G0_HI  = 20'hFFFE1;
  localparam logic [19:0] ADDR_REQ_G1_LO  = 20'hFFFE2;
  localparam logic [19:0] ADDR_REQ_G1_HI  = 20'hFFFE3;
  localparam logic [19:0] ADDR_REQ_G2_LO  = 20'hFFFD0;
  localparam logic [19:0] ADDR_REQ_G2_HI  = 20'hFFFD1;
  localparam logic [19:0] ADDR_REQ_G3_LO  = 20'hFFFD2;
  localparam logic [19:0] ADDR_REQ_G3_HI  = 20'hFFFD3;
  // byte addresses of the mask flag registers
  localparam logic [19:0] ADDR_MASK_G0_LO = 20'hFFFE4;
  localparam logic [19:0] ADDR_MASK_G0_HI = 20'hFFFE5;
  localparam logic [19:0] ADDR_MASK_G1_LO = 20'hFFFE6;
  localparam logic [19:0] ADDR_MASK_G1_HI = 20'hFFFE7;
  localparam logic [19:0] ADDR_MASK_G2_LO = 20'hFFFD4;
  localparam logic [19:0] ADDR_MASK_G2_HI = 20'hFFFD5;
  localparam logic [19:0] ADDR_MASK_G3_LO = 20'hFFFD6;
  localparam logic [19:0] ADDR_MASK_G3_HI = 20'hFFFD7;

  // reset values
  localparam logic [7:0]  REQ_RESET  = 8'h00;
  localparam logic [7:0]  MASK_RESET = 8'hFF;

  // flag bits that have a source; top three bits of group 3 high do not
  localparam logic [63:0] IMPL_BITS = 64'h1FFF_FFFF_FFFF_FFFF;

  // flag shared by the external pin six and key return sources
  localparam logic [5:0]  SHARED_BIT = 6'h23;

  // extra execution clocks added by a flag register write
  localparam logic [1:0]  WR_EXTRA_CLKS = 2'h2;

  // priority level of the lowest class
  localparam logic [1:0]  LEVEL_LOWEST = 2'h3;

  // access width of a memory manipulation
  typedef enum logic [1:0] {
    SZ_BIT  = 2'b00,
    SZ_BYTE = 2'b01,
    SZ_WORD = 2'b10
  } irmf_size_t;

endpackage

// [hdl/irmf_prio_pick.sv]
`timescale 1ns/1ps
// picks the winning request: best level first, lowest position on a tie
module irmf_prio_pick #(
  parameter int N = 64
) (
  input  wire logic [N-1:0] pend_i,        // pending and unmasked flags
  input  wire logic [N-1:0] prio_lo_i,     // priority low bit per source
  input  wire logic [N-1:0] prio_hi_i,     // priority high bit per source
  output logic              found_o,       // some request is pending
  output logic [5:0]        idx_o,         // winning flag position
  output logic [1:0]        level_o        // winning priority level
);

  // scan from the last position down so that a lower position wins ties
  always_comb begin
    found_o = 1'b0;
    idx_o   = '0;
    level_o = irmf_pkg::LEVEL_LOWEST;
    for (int i = N - 1; i >= 0; i--) begin
      // 00 is level 0 the best, 11 is level 3 the worst (see R15)
      if (pend_i[i] && ({prio_hi_i[i], prio_lo_i[i]} <= level_o)) begin
        found_o = 1'b1;
        idx_o   = 6'(i);                   // see R16
        level_o = {prio_hi_i[i], prio_lo_i[i]};
      end
    end
  end

endmodule

// [sim/irmf_core_model.sv]
`timescale 1ns/1ps
// core side: acknowledges the request it is shown, after a chosen delay
module irmf_core_model (
  input  wire logic       core_clk_i, // system clock
  input  wire logic       reset_n_i,  // async reset, active low
  input  wire logic       ack_en_i,   // core accepts interrupts
  input  wire logic [3:0] ack_dly_i,  // cycles to wait before acking
  input  wire logic       irq_req_i,  // request from the flag block
  input  wire logic [5:0] irq_idx_i,  // requesting position
  output logic            ack_o,      // acknowledge pulse
  output logic [5:0]      ack_idx_o   // acknowledged position
);
  logic [3:0] wait_cnt; // cycles seen with a request
  logic [1:0] cool;     // holdoff: the request output lags the clear

  // one behavioural process, changes only on the clock edge or the reset edge
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_o     <= 1'b0;
      ack_idx_o <= 6'h00;
      wait_cnt  <= 4'h0;
      cool      <= 2'h0;
    end else if (!ack_en_i || !irq_req_i || cool != 2'h0) begin
      // idle: the index toggles so no one leans on a stale value
      ack_o     <= 1'b0;
      ack_idx_o <= ~ack_idx_o;
      wait_cnt  <= 4'h0;
      if (cool != 2'h0) cool <= cool - 2'h1;
    end else if (wait_cnt == ack_dly_i) begin
      // one pulse per service; holdoff avoids acking the lagging copy
      ack_o     <= 1'b1;
      ack_idx_o <= irq_idx_i;
      wait_cnt  <= 4'h0;
      cool      <= 2'h3;
    end else begin
      // slow core: keep counting while the request stands
      ack_o     <= 1'b0;
      ack_idx_o <= ~ack_idx_o;
      wait_cnt  <= wait_cnt + 4'h1;
    end
  end
endmodule

// [sim/interrupt_request_mask_flags_bench.sv]
`timescale 1ns/1ps
// plays core and software against the flag block and checks replies
module interrupt_request_mask_flags_bench;
  logic        core_clk_i;        // system clock
  logic        reset_n_i;         // reset, active low
  logic        mem_sel_i;         // access strobe
  logic        mem_we_i;          // write when high
  logic [1:0]  mem_size_i;        // access width
  logic [19:0] mem_addr_i;        // byte address
  logic [2:0]  mem_bit_i;         // bit number
  logic [15:0] mem_wdata_i;       // write data
  logic        mem_busy_o;        // write stall
  logic        mem_rvalid_o;      // read answer
  logic [15:0] mem_rdata_o;       // read data
  logic [63:0] src_req_i;         // source pulses
  logic        ext_pin_irq_six_i; // pin six pulse
  logic        key_return_irq_i;  // key return pulse
  logic [63:0] prio_lo;           // priority low bits
  logic [63:0] prio_hi;           // priority high bits
  logic        ack_i;             // core acknowledge
  logic [5:0]  ack_idx_i;         // acknowledged position
  logic        irq_req_o;         // request to the core
  logic [5:0]  irq_idx_o;         // winning position
  logic [1:0]  irq_level_o;       // winning level
  logic        ack_en;            // core takes interrupts
  logic [3:0]  ack_dly;           // core reaction delay
  int          mismatches;        // failed comparisons
  int          num_checks;        // comparisons made
  // short aliases keep the call lines readable
  localparam logic [1:0]  SB   = irmf_pkg::SZ_BIT;
  localparam logic [1:0]  SY   = irmf_pkg::SZ_BYTE;
  localparam logic [1:0]  SW   = irmf_pkg::SZ_WORD;
  localparam logic [19:0] REQ0 = irmf_pkg::ADDR_REQ_G0_LO;
  localparam logic [19:0] REQ1 = irmf_pkg::ADDR_REQ_G1_LO;
  localparam logic [19:0] REQ2 = irmf_pkg::ADDR_REQ_G2_LO;
  localparam logic [19:0] MSK0 = irmf_pkg::ADDR_MASK_G0_LO;
  localparam logic [19:0] MSK1 = irmf_pkg::ADDR_MASK_G1_LO;
  localparam logic [19:0] MSK2 = irmf_pkg::ADDR_MASK_G2_LO;
  localparam logic [7:0]  REQ_RST = irmf_pkg::REQ_RESET;
  localparam logic [7:0]  MSK_RST = irmf_pkg::MASK_RESET;

  irmf_flags irmf_flags_i (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .mem_sel_i(mem_sel_i),
    .mem_we_i(mem_we_i), .mem_size_i(mem_size_i), .mem_addr_i(mem_addr_i),
    .mem_bit_i(mem_bit_i), .mem_wdata_i(mem_wdata_i),
    .mem_busy_o(mem_busy_o), .mem_rvalid_o(mem_rvalid_o),
    .mem_rdata_o(mem_rdata_o), .src_req_i(src_req_i),
    .ext_pin_irq_six_i(ext_pin_irq_six_i),
    .key_return_irq_i(key_return_irq_i), .priority_bit_low_i(prio_lo),
    .priority_bit_high_i(prio_hi), .ack_i(ack_i), .ack_idx_i(ack_idx_i),
    .irq_req_o(irq_req_o), .irq_idx_o(irq_idx_o),
    .irq_level_o(irq_level_o)
  );

  irmf_core_model irmf_core_model_i (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ack_en_i(ack_en),
    .ack_dly_i(ack_dly), .irq_req_i(irq_req_o), .irq_idx_i(irq_idx_o),
    .ack_o(ack_i), .ack_idx_o(ack_idx_i)
  );

  // 125 MHz system clock
  always #4 core_clk_i = ~core_clk_i;

  // verdict and end of run, also reached from a timed-out wait
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // the single comparison used for every result except the request level in wait_irq
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // write; bus lines are scrambled after release, then the stall counted
  task automatic wr(input logic [1:0] sz, input logic [19:0] a,
                    input logic [2:0] b, input logic [15:0] d,
                    input int stall);
    int n;
    @(posedge core_clk_i); #1;
    mem_sel_i = 1'b1; mem_we_i = 1'b1; mem_size_i = sz;
    mem_addr_i = a; mem_bit_i = b; mem_wdata_i = d;
    @(posedge core_clk_i); #1;
    mem_sel_i = 1'b0; mem_addr_i = ~a; mem_wdata_i = ~d;
    n = 0;
    while (mem_busy_o === 1'b1 && n < 8) begin
      @(posedge core_clk_i); #1;
      n++;
    end
    chk("write stall", 16'(stall), 16'(n));
    // a stall that never ends has already counted; stop here
    if (n >= 8) report_and_stop();
  endtask

  // read; the answer stands for one cycle right after the taking edge
  task automatic rchk(input logic [1:0] sz, input logic [19:0] a,
                      input logic [2:0] b, input logic [15:0] exp);
    @(posedge core_clk_i); #1;
    mem_sel_i = 1'b1; mem_we_i = 1'b0; mem_size_i = sz;
    mem_addr_i = a; mem_bit_i = b;
    @(posedge core_clk_i); #1;
    mem_sel_i = 1'b0; mem_addr_i = ~a;
    chk("read valid", 16'h0001, {15'h0000, mem_rvalid_o});
    chk($sformatf("data at %h", a), exp, mem_rdata_o);
  endtask

  // bounded wait for the core request level, then the winner
  task automatic wait_irq(input logic exp, input logic [5:0] idx,
                          input logic [1:0] lvl, input int lim);
    int n;
    n = 0;
    while (irq_req_o !== exp && n < lim) begin
      @(posedge core_clk_i); #1;
      n++;
    end
    if (irq_req_o !== exp) begin
      mismatches++;
      $display("wrong value irq request expected %b seen %b", exp,
               irq_req_o);
      report_and_stop();
    end
    if (exp) begin
      chk("winner index", {10'h000, idx}, {10'h000, irq_idx_o});
      chk("winner level", 16'(lvl), 16'(irq_level_o));
    end
  endtask

  // one-cycle source pulse
  task automatic pulse(input logic [63:0] v);
    @(posedge core_clk_i); #1;
    src_req_i = v;
    @(posedge core_clk_i); #1;
    src_req_i = 64'h0;
  endtask

  initial begin
    core_clk_i = 1'b0; reset_n_i = 1'b0; mem_sel_i = 1'b0;
    mem_we_i = 1'b0; mem_size_i = 2'h0; mem_addr_i = 20'h00000;
    mem_bit_i = 3'h0; mem_wdata_i = 16'h0000; src_req_i = 64'h0;
    ext_pin_irq_six_i = 1'b0; key_return_irq_i = 1'b0;
    prio_lo = '1; prio_hi = '1; ack_en = 1'b0; ack_dly = 4'h0;
    mismatches = 0; num_checks = 0;
    repeat (4) @(posedge core_clk_i);
    #1 reset_n_i = 1'b1;
    // reset values of every byte register, then unmapped space
    for (int i = 0; i < 4; i++) begin
      rchk(SY, REQ0 + 20'(i), 3'h0, {8'h00, REQ_RST});
      rchk(SY, REQ2 + 20'(i), 3'h0, {8'h00, REQ_RST});
      rchk(SY, MSK0 + 20'(i), 3'h0, {8'h00, MSK_RST});
      rchk(SY, MSK2 + 20'(i), 3'h0, {8'h00, MSK_RST});
    end
    wr(SY, 20'hFFFC0, 3'h0, 16'h00AA, 0);
    rchk(SY, 20'hFFFC0, 3'h0, 16'h0000);
    // byte writes: absent flags left 0, absent masks left 1
    for (int i = 0; i < 4; i++) begin
      wr(SY, REQ0 + 20'(i), 3'h0, 16'h0015, 2);
      wr(SY, REQ2 + 20'(i), 3'h0, 16'h0015, 2);
      wr(SY, MSK0 + 20'(i), 3'h0, 16'h00F5, 2);
      wr(SY, MSK2 + 20'(i), 3'h0, 16'h00F5, 2);
    end
    wr(SW, REQ1, 3'h0, 16'h0510, 2);
    rchk(SY, REQ1, 3'h0, 16'h0010);
    rchk(SY, REQ1 + 20'h1, 3'h0, 16'h0005);
    // a word read at the odd byte is aligned down to the pair
    rchk(SW, REQ1 + 20'h1, 3'h0, 16'h0510);
    rchk(SW, REQ0, 3'h0, 16'h1515);
    rchk(SW, MSK2 + 20'h2, 3'h0, 16'hF5F5);
    rchk(SB, REQ2, 3'h2, 16'h0001);
    rchk(SB, REQ2, 3'h1, 16'h0000);
    chk("masked request", 16'h0000, {15'h0000, irq_req_o});
    // back to reset contents through word writes
    for (int i = 0; i < 4; i += 2) begin
      wr(SW, REQ0 + 20'(i), 3'h0, 16'h0000, 2);
      wr(SW, REQ2 + 20'(i), 3'h0, 16'h0000, 2);
      wr(SW, MSK0 + 20'(i), 3'h0, 16'hFFFF, 2);
      wr(SW, MSK2 + 20'(i), 3'h0, 16'hFFFF, 2);
    end
    // reserved size code stalls but leaves the flags alone
    wr(2'h3, REQ0, 3'h0, 16'hFFFF, 2);
    // a masked source still sets its flag; unmasking forwards it
    pulse(64'h1 << 5);
    rchk(SY, REQ0, 3'h0, 16'h0020);
    rchk(2'h3, REQ0, 3'h0, 16'h0000);
    chk("masked request", 16'h0000, {15'h0000, irq_req_o});
    wr(SB, MSK0, 3'h5, 16'h0000, 2);
    wait_irq(1'b1, 6'd5, 2'h3, 10);
    ack_en = 1'b1;
    wait_irq(1'b0, 6'd0, 2'h0, 10);
    ack_en = 1'b0;
    rchk(SY, REQ0, 3'h0, 16'h0000);
    // both shared sources land on one flag; bit clear in between
    @(posedge core_clk_i); #1 ext_pin_irq_six_i = 1'b1;
    @(posedge core_clk_i); #1 ext_pin_irq_six_i = 1'b0;
    rchk(SY, REQ2, 3'h0, 16'h0008);
    wr(SB, REQ2, 3'h3, 16'h0000, 2);
    rchk(SY, REQ2, 3'h0, 16'h0000);
    @(posedge core_clk_i); #1 key_return_irq_i = 1'b1;
    @(posedge core_clk_i); #1 key_return_irq_i = 1'b0;
    rchk(SY, REQ2, 3'h0, 16'h0008);
    wr(SB, MSK2, 3'h3, 16'h0000, 2);
    wait_irq(1'b1, irmf_pkg::SHARED_BIT, 2'h3, 10);
    ack_en = 1'b1; ack_dly = 4'h3;
    wait_irq(1'b0, 6'd0, 2'h0, 12);
    ack_en = 1'b0; ack_dly = 4'h0;
    // three requests at once: level first, then position
    wr(SB, MSK2 + 20'h1, 3'h0, 16'h0000, 2);
    prio_hi[40] = 1'b0;
    pulse((64'h1 << 5) | (64'h1 << 35) | (64'h1 << 40));
    wait_irq(1'b1, 6'd40, 2'h1, 10);
    prio_hi[40] = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1 wait_irq(1'b1, 6'd5, 2'h3, 10);
    prio_hi[35] = 1'b0; prio_lo[35] = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1 wait_irq(1'b1, 6'd35, 2'h0, 10);
    prio_hi = '1; prio_lo = '1; ack_en = 1'b1;
    wait_irq(1'b0, 6'd0, 2'h0, 30);
    ack_en = 1'b0;
    rchk(SY, REQ0, 3'h0, 16'h0000);
    rchk(SW, REQ2, 3'h0, 16'h0000);
    // reset in mid-run with a pending, unmasked request
    wr(SY, REQ1, 3'h0, 16'h0001, 2);
    wr(SY, MSK1, 3'h0, 16'h00FE, 2);
    wait_irq(1'b1, 6'd16, 2'h3, 10);
    @(posedge core_clk_i); #1 reset_n_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1 reset_n_i = 1'b1;
    chk("request after reset", 16'h0000, {15'h0000, irq_req_o});
    rchk(SY, REQ1, 3'h0, {8'h00, REQ_RST});
    rchk(SY, MSK1, 3'h0, {8'h00, MSK_RST});
    report_and_stop();
  end
endmodule
